// ==== rtl/msc_pkg.sv ====
package msc_pkg;
   // clock figures
   localparam int unsigned XTAL_HZ     = 16_000_000;
   localparam int unsigned RTC_HZ      = 32_768;
   localparam int unsigned SYM_HZ      = 62_500;
   localparam int unsigned PRESC_RATIO = XTAL_HZ / SYM_HZ;
   localparam int unsigned PRESC_W     = $clog2(PRESC_RATIO);
   localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(PRESC_RATIO - 1);
   // rtc correction: symbols per rtc edge as a fraction over RTC_HZ
   localparam int unsigned ACC_W       = $clog2(RTC_HZ);
   localparam logic [ACC_W+1:0] SYM_PER_RTC = (ACC_W + 2)'(SYM_HZ);
   // back-off slot
   localparam int unsigned SLOT_SYMBOLS = 20;
   localparam logic [4:0]  SLOT_LAST    = 5'(SLOT_SYMBOLS - 1);
   // counter
   localparam int unsigned CNT_W      = 32;
   localparam logic [CNT_W-1:0] CNT_RESET = 32'h0000_0000;
   // register word index, byte address is four times it
   localparam logic [3:0] REG_CNT_B0   = 4'h0;
   localparam logic [3:0] REG_CNT_B1   = 4'h1;
   localparam logic [3:0] REG_CNT_B2   = 4'h2;
   localparam logic [3:0] REG_CNT_B3   = 4'h3;
   localparam logic [3:0] REG_CTRL0    = 4'h4;
   localparam logic [3:0] REG_STATUS   = 4'h5;
   localparam logic [3:0] REG_IRQ_FLAG = 4'h6;
   localparam logic [3:0] REG_IRQ_MASK = 4'h7;
   // field positions
   localparam int unsigned CTRL_CLK_SEL_BIT = 0;
   localparam int unsigned STAT_BUSY_BIT    = 0;
   localparam int unsigned IRQ_OVF_BIT      = 0;
   localparam int unsigned IRQ_SLOT_BIT     = 1;
   localparam int unsigned IRQ_W            = 2;
   localparam logic [IRQ_W-1:0] IRQ_RESET   = 2'h0;
   localparam logic SRC_XTAL = 1'b0;
   localparam logic SRC_RTC  = 1'b1;
   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_DONE = 1'b1
   } msc_bus_state_type;
endpackage

// ==== rtl/msc_tick_if.sv ====
interface msc_tick_if;
   logic sym_tick;
   logic step_two;
   logic xtal_sym;
   logic src_rtc;
   logic presc_clr;
   logic trx_sleep;
   modport gen  (output sym_tick, output step_two, output xtal_sym,
                 input src_rtc, input presc_clr);
   modport core (input sym_tick, input step_two, input xtal_sym,
                 output src_rtc, output presc_clr, output trx_sleep);
   modport slot (input xtal_sym, input presc_clr, input trx_sleep);
endinterface

// ==== rtl/msc_tick_gen.sv ====
module msc_tick_gen
   import msc_pkg::*;
(
   // clock and reset
   input  wire logic core_clk,
   input  wire logic arst_n,
   // oscillator pins
   input  wire logic crystal_input,
   input  wire logic rtc_osc_input,
   // towards the counter
   msc_tick_if.gen   tk
);
   typedef struct packed {
      logic [2:0]         xs;
      logic [2:0]         rs;
      logic [PRESC_W-1:0] presc;
      logic [ACC_W-1:0]   acc;
      logic               xsym;
      logic               tick;
      logic               two;
   } msc_gen_state_type;

   msc_gen_state_type st_ff;
   msc_gen_state_type nxt_st;

   always_comb begin
      logic             xedge;
      logic             redge;
      logic [ACC_W+1:0] sum;
      xedge = 1'b0;
      redge = 1'b0;
      sum   = '0;
      nxt_st = st_ff;
      // xs[0]/rs[0] feed only the next stage
      nxt_st.xs = {st_ff.xs[1:0], crystal_input};
      nxt_st.rs = {st_ff.rs[1:0], rtc_osc_input};
      xedge = st_ff.xs[1] & ~st_ff.xs[2];
      redge = st_ff.rs[1] & ~st_ff.rs[2];
      nxt_st.xsym = 1'b0;
      if (tk.presc_clr) begin
         nxt_st.presc = '0;
      end else if (xedge) begin
         nxt_st.presc = st_ff.presc + 1'b1;
         nxt_st.xsym  = (st_ff.presc == PRESC_LAST);
      end
      nxt_st.tick = 1'b0;
      nxt_st.two  = 1'b0;
      if (tk.src_rtc) begin
         if (redge) begin
            // fractional accumulation keeps drift under one symbol
            sum         = {2'b00, st_ff.acc} + SYM_PER_RTC;
            nxt_st.acc  = sum[ACC_W-1:0];
            nxt_st.two  = sum[ACC_W+1];
            nxt_st.tick = 1'b1;
         end
      end else begin
         nxt_st.tick = nxt_st.xsym;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign tk.sym_tick = st_ff.tick;
   assign tk.step_two = st_ff.two;
   assign tk.xtal_sym = st_ff.xsym;
endmodule

// ==== rtl/msc_slot_counter.sv ====
module msc_slot_counter
   import msc_pkg::*;
(
   // clock and reset
   input  wire logic core_clk,
   input  wire logic arst_n,
   // symbol timing
   msc_tick_if.slot  tk,
   // slot boundary pulse
   output logic      slot_pulse
);
   typedef struct packed {
      logic [4:0] cnt;
      logic       pulse;
   } msc_slot_state_type;

   msc_slot_state_type st_ff;
   msc_slot_state_type nxt_st;

   always_comb begin
      nxt_st       = st_ff;
      nxt_st.pulse = 1'b0;
      // stopped with the transceiver clock, restarted by a resync
      if (tk.trx_sleep || tk.presc_clr) begin
         nxt_st.cnt = '0;
      end else if (tk.xtal_sym) begin
         if (st_ff.cnt == SLOT_LAST) begin
            nxt_st.cnt   = '0;
            nxt_st.pulse = 1'b1;
         end else begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign slot_pulse = st_ff.pulse;
endmodule

// ==== rtl/msc_top.sv ====
// Behaviour
// - 32-bit counter advances at symbol rate from crystal or rtc source.
// - transceiver sleep forces the rtc source so counting continues.
// - clock-select bit always reads the source actually in use.
// - clock-select writes are dropped while the transceiver sleeps.
// - on wake the source chosen before sleep is restored.
// - switching rtc to crystal clears the crystal prescaler.
// - reading the low byte snapshots the word; upper bytes read the snapshot.
// - upper bytes are staged; writing the low byte commits all 32 bits.
// - one staging register is shared by counter read snapshots and write staging.
// - low-byte and upper-byte reads both answer one clock after the request.
// - on rtc source a commit loads at the next counter tick.
// - on crystal source a commit loads at once.
// - busy flag stands high while a counter load is pending.
// - wrap from all ones to zero raises the overflow event.
// - rtc counting corrects drift to within one symbol.
// - back-off slot pulse every twenty symbols, only while transceiver runs.
// - events set flags regardless of mask; mask gates irq; write one clears.
//
// Register access over Avalon-MM and the register addresses were left to the implementer.
module msc_top
   import msc_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   // avalon-mm slave
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // oscillator pins
   input  wire logic        crystal_input,
   input  wire logic        rtc_osc_input,
   // transceiver power state, high while asleep
   input  wire logic        trx_sleep,
   // interrupt request
   output logic             irq
);
   typedef struct packed {
      msc_bus_state_type  bus;
      logic               wait_rq;
      logic [31:0]        rdata;
      logic [1:0]         slp_sync;
      logic               slp_q;
      logic [CNT_W-1:0]   count;
      logic [23:0]        temp;
      logic [CNT_W-1:0]   pend_val;
      logic               pend;
      logic               src_active;
      logic               src_user;
      logic               presc_clr;
      logic [IRQ_W-1:0]   flags;
      logic [IRQ_W-1:0]   mask;
      logic               irq;
   } msc_top_state_type;

   msc_top_state_type st_ff;
   msc_top_state_type nxt_st;

   msc_tick_if tk ();
   logic       slot_pulse;

   msc_tick_gen u_tick_gen (
      .core_clk      (core_clk),
      .arst_n        (arst_n),
      .crystal_input (crystal_input),
      .rtc_osc_input (rtc_osc_input),
      .tk            (tk)
   );

   msc_slot_counter u_slot_counter (
      .core_clk   (core_clk),
      .arst_n     (arst_n),
      .tk         (tk),
      .slot_pulse (slot_pulse)
   );

   // byte n of a word, n in 0..3
   function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] n);
      byte_of = w[8*n +: 8];
   endfunction

   // register word index of a byte address
   function automatic logic [3:0] reg_index(input logic [5:0] a);
      reg_index = a[5:2];
   endfunction

   always_comb begin
      logic              req;
      logic              acc_wr;
      logic              lane0;
      logic [3:0]        idx;
      logic [7:0]        wbyte;
      logic [CNT_W:0]    sum;
      logic [CNT_W-1:0]  step;
      logic [IRQ_W-1:0]  set_ev;
      logic [IRQ_W-1:0]  clr_ev;
      logic              slp;
      logic              new_src;
      req     = 1'b0;
      acc_wr  = 1'b0;
      lane0   = 1'b0;
      idx     = '0;
      wbyte   = '0;
      sum     = '0;
      step    = '0;
      set_ev  = '0;
      clr_ev  = '0;
      slp     = 1'b0;
      new_src = 1'b0;
      nxt_st  = st_ff;

      req   = avs_read | avs_write;
      idx   = reg_index(avs_address);
      lane0 = avs_byteenable[0];
      wbyte = avs_writedata[7:0];

      // sleep level from the transceiver domain, two stages first
      nxt_st.slp_sync = {st_ff.slp_sync[0], trx_sleep};
      slp             = st_ff.slp_sync[1];
      nxt_st.slp_q    = slp;
      nxt_st.presc_clr = 1'b0;

      // bus: answer one cycle after the request is seen
      nxt_st.bus     = BUS_IDLE;
      nxt_st.wait_rq = 1'b1;
      case (st_ff.bus)
         BUS_IDLE: begin
            if (req) begin
               nxt_st.bus     = BUS_DONE;
               nxt_st.wait_rq = 1'b0;
               nxt_st.rdata   = '0;
               if (avs_read) begin
                  case (idx)
                     REG_CNT_B0: begin
                        nxt_st.rdata[7:0] = byte_of(st_ff.count, 2'd0);
                        nxt_st.temp       = st_ff.count[31:8];
                     end
                     REG_CNT_B1: nxt_st.rdata[7:0] = st_ff.temp[7:0];
                     REG_CNT_B2: nxt_st.rdata[7:0] = st_ff.temp[15:8];
                     REG_CNT_B3: nxt_st.rdata[7:0] = st_ff.temp[23:16];
                     REG_CTRL0: nxt_st.rdata[CTRL_CLK_SEL_BIT] = st_ff.src_active;
                     REG_STATUS: nxt_st.rdata[STAT_BUSY_BIT] = st_ff.pend;
                     REG_IRQ_FLAG: nxt_st.rdata[IRQ_W-1:0] = st_ff.flags;
                     REG_IRQ_MASK: nxt_st.rdata[IRQ_W-1:0] = st_ff.mask;
                     default: nxt_st.rdata = '0;
                  endcase
               end
            end
         end
         BUS_DONE: begin
            // the master samples waitrequest low at this edge
            acc_wr = avs_write & lane0;
         end
         default: begin
            nxt_st.bus     = BUS_IDLE;
            nxt_st.wait_rq = 1'b1;
         end
      endcase

      // clock source selection and sleep handling
      new_src = st_ff.src_active;
      if (slp && !st_ff.slp_q) begin
         nxt_st.src_user = st_ff.src_active;
         new_src         = SRC_RTC;
      end else if (!slp && st_ff.slp_q) begin
         new_src = st_ff.src_user;
      end else if (acc_wr && idx == REG_CTRL0 && !slp) begin
         new_src         = wbyte[CTRL_CLK_SEL_BIT];
         nxt_st.src_user = wbyte[CTRL_CLK_SEL_BIT];
      end
      nxt_st.src_active = new_src;
      if (st_ff.src_active == SRC_RTC && new_src == SRC_XTAL) begin
         nxt_st.presc_clr = 1'b1;
      end

      // staging and commit through the shared temporary register
      if (acc_wr) begin
         case (idx)
            REG_CNT_B1: nxt_st.temp[7:0]   = wbyte;
            REG_CNT_B2: nxt_st.temp[15:8]  = wbyte;
            REG_CNT_B3: nxt_st.temp[23:16] = wbyte;
            REG_CNT_B0: begin
               nxt_st.pend_val = {st_ff.temp, wbyte};
               nxt_st.pend     = 1'b1;
            end
            default: nxt_st.pend = st_ff.pend;
         endcase
      end

      // counter: a pending load wins over the count step
      step = tk.step_two ? CNT_W'(2) : CNT_W'(1);
      if (st_ff.pend && (st_ff.src_active == SRC_XTAL || tk.sym_tick)) begin
         nxt_st.count = st_ff.pend_val;
         nxt_st.pend  = 1'b0;
         if (acc_wr && idx == REG_CNT_B0) begin
            nxt_st.pend = 1'b1;
         end
      end else if (tk.sym_tick) begin
         sum          = {1'b0, st_ff.count} + {1'b0, step};
         nxt_st.count = sum[CNT_W-1:0];
         set_ev[IRQ_OVF_BIT] = sum[CNT_W];
      end

      // interrupt flags: a new event outranks a same-cycle clear
      set_ev[IRQ_SLOT_BIT] = slot_pulse;
      if (acc_wr && idx == REG_IRQ_FLAG) begin
         clr_ev = wbyte[IRQ_W-1:0];
      end
      if (acc_wr && idx == REG_IRQ_MASK) begin
         nxt_st.mask = wbyte[IRQ_W-1:0];
      end
      nxt_st.flags = (st_ff.flags & ~clr_ev) | set_ev;
      nxt_st.irq   = |(nxt_st.flags & nxt_st.mask);
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff            <= '0;
         st_ff.bus        <= BUS_IDLE;
         st_ff.wait_rq    <= 1'b1;
         st_ff.count      <= CNT_RESET;
         st_ff.src_active <= SRC_XTAL;
         st_ff.src_user   <= SRC_XTAL;
         st_ff.flags      <= IRQ_RESET;
         st_ff.mask       <= IRQ_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign tk.src_rtc   = st_ff.src_active;
   assign tk.presc_clr = st_ff.presc_clr;
   assign tk.trx_sleep = st_ff.slp_sync[1];

   assign avs_readdata    = st_ff.rdata;
   assign avs_waitrequest = st_ff.wait_rq;
   assign irq             = st_ff.irq;
endmodule

// ==== tb/msc_chk.sv ====
module msc_chk
   import msc_pkg::*;
(
   // clock and reset
   input wire logic        core_clk,
   input wire logic        arst_n,
   // bus
   input wire logic [5:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // power state and interrupt
   input wire logic        trx_sleep,
   input wire logic        irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   logic       mask_seen_ff;
   logic [3:0] sleep_cnt_ff;
   wire        req   = (avs_read | avs_write) & avs_waitrequest;
   wire        ans_w = !avs_waitrequest & avs_write & avs_byteenable[0];
   wire        mask_w = ans_w && avs_address[5:2] == REG_IRQ_MASK;
   // sticky: irq falls at the same edge as a mask clear, with no lag
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         mask_seen_ff <= 1'b0;
         sleep_cnt_ff <= 4'h0;
      end else begin
         mask_seen_ff <= mask_seen_ff | (mask_w && avs_writedata[1:0] != 2'h0);
         sleep_cnt_ff <= !trx_sleep ? 4'h0 : (sleep_cnt_ff == 4'hf ? 4'hf : sleep_cnt_ff + 4'h1);
      end
   end
   answer_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer lasted more than one cycle");
   take_answer_a: assert property (req |=> !avs_waitrequest)
      else $error("request not answered in the next cycle");
   low_byte_time_a: assert property ((req && avs_read && avs_address[5:2] == REG_CNT_B0)
      |-> ##[1:3] !avs_waitrequest) else $error("low byte read too slow");
   upper_byte_time_a: assert property ((req && avs_read && avs_address[5:4] == 2'h0
      && avs_address[3:2] != 2'h0) |-> ##[1:2] !avs_waitrequest) else $error("upper read slow");
   data_width_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
      else $error("upper read data bits not zero");
   unmapped_zero_a: assert property (req && avs_read && avs_address[5] |=> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   data_hold_a: assert property (avs_waitrequest && !$past(avs_waitrequest) |-> $stable(avs_readdata))
      else $error("read data changed after answer");
   mask_gate_a: assert property (irq |-> mask_seen_ff)
      else $error("irq without any mask bit set");
   mask_clear_a: assert property (mask_w && avs_writedata[1:0] == 2'h0 |-> ##2 !irq)
      else $error("irq stayed high after mask cleared");
   sleep_source_a: assert property ((req && avs_read && avs_address[5:2] == REG_CTRL0
      && sleep_cnt_ff == 4'hf) |=> avs_readdata[0]) else $error("sleep source not rtc");
   cover property (ans_w && avs_address[5:2] == REG_CNT_B0);
   cover property ($rose(irq));
   cover property (req && avs_read && sleep_cnt_ff == 4'hf);
endmodule
bind msc_top msc_chk u_chk (.core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .trx_sleep(trx_sleep), .irq(irq));

// ==== tb/mac_symbol_counter_bench.sv ====
module mac_symbol_counter_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import msc_pkg::*;
   logic        core_clk = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic        crystal_input = 1'b0, rtc_osc_input = 1'b0, trx_sleep = 1'b0;
   logic [5:0]  avs_address = 6'h0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'h1;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest, irq;
   logic [7:0]  q;
   int          errors = 0, n_compared = 0, cyc = 0, t0 = 0;
   msc_top uut (.core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .crystal_input(crystal_input),
      .rtc_osc_input(rtc_osc_input), .trx_sleep(trx_sleep), .irq(irq));
   initial begin
      forever #12.5 core_clk = ~core_clk;
   end
   initial begin
      forever #31.25 crystal_input = ~crystal_input;
   end
   initial begin
      forever #15258.789 rtc_osc_input = ~rtc_osc_input;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // answer is sampled as it stood before the edge, so no race with the flops
   task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] d);
      @(posedge core_clk);
      avs_address <= {idx, 2'b00};
      avs_read <= !w;
      avs_write <= w;
      avs_writedata <= {24'h0, d};
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h0);
      chk(q, exp);
   endtask
   task automatic wcnt(input logic [31:0] val);
      for (int i = 3; i >= 0; i--) bus(1'b1, 4'(i), val[8*i +: 8]);
   endtask
   task automatic rcnt(input logic [31:0] exp);
      for (int i = 0; i < 4; i++) rd(4'(i), exp[8*i +: 8]);
   endtask
   // an rtc to crystal switch gives a known prescaler phase from t0
   task automatic to_xtal();
      bus(1'b1, REG_CTRL0, 8'h01);
      bus(1'b1, REG_CTRL0, 8'h00);
      t0 = cyc;
   endtask
   task automatic wait_to(input int c);
      while (cyc < c) @(posedge core_clk);
   endtask
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         errors++;
         conclude();
      end
   end
   initial begin
      repeat (4) @(posedge core_clk);
      arst_n <= 1'b1;
      rd(REG_CTRL0, 8'h00);
      rd(REG_STATUS, 8'h00);
      rd(REG_IRQ_FLAG, 8'h00);
      rd(REG_IRQ_MASK, 8'h00);
      rd(4'h9, 8'h00);
      avs_byteenable <= 4'h0;
      bus(1'b1, REG_CTRL0, 8'h01);
      avs_byteenable <= 4'h1;
      rd(REG_CTRL0, 8'h00);
      rd(REG_CNT_B0, 8'h00);
      $display("test reset done");
      to_xtal();
      wcnt(32'h1234_5678);
      rd(REG_STATUS, 8'h00);
      rcnt(32'h1234_5678);
      bus(1'b0, REG_CNT_B0, 8'h0);
      bus(1'b1, REG_CNT_B3, 8'haa);
      rd(REG_CNT_B3, 8'haa);
      wait_to(t0 + 620);
      rd(REG_CNT_B0, 8'h78);
      wait_to(t0 + 670);
      rd(REG_CNT_B0, 8'h79);
      $display("test crystal done");
      to_xtal();
      wcnt(32'hffff_ffff);
      wait_to(t0 + 670);
      bus(1'b0, REG_IRQ_FLAG, 8'h0);
      chk(q & 8'h01, 8'h01);
      rcnt(32'h0);
      bus(1'b1, REG_IRQ_MASK, 8'h01);
      repeat (3) @(posedge core_clk);
      chk({7'h0, irq}, 8'h01);
      bus(1'b1, REG_IRQ_FLAG, 8'h01);
      bus(1'b0, REG_IRQ_FLAG, 8'h0);
      chk(q & 8'h01, 8'h00);
      chk({7'h0, irq}, 8'h00);
      bus(1'b1, REG_IRQ_MASK, 8'h00);
      $display("test overflow done");
      bus(1'b1, REG_CTRL0, 8'h01);
      wcnt(32'h0000_0100);
      rd(REG_STATUS, 8'h01);
      for (int i = 0; i < 1000 && q !== 8'h00; i++) bus(1'b0, REG_STATUS, 8'h0);
      t0 = cyc;
      chk(q, 8'h00);
      rcnt(32'h0000_0100);
      // ten rtc edges carry about 19.07 symbols
      wait_to(t0 + 12817);
      bus(1'b0, REG_CNT_B0, 8'h0);
      chk({7'h0, q inside {8'h12, 8'h13, 8'h14}}, 8'h01);
      $display("test rtc done");
      to_xtal();
      trx_sleep <= 1'b1;
      repeat (20) @(posedge core_clk);
      rd(REG_CTRL0, 8'h01);
      bus(1'b1, REG_CTRL0, 8'h00);
      rd(REG_CTRL0, 8'h01);
      bus(1'b1, REG_IRQ_FLAG, 8'h03);
      repeat (13000) @(posedge core_clk);
      bus(1'b0, REG_IRQ_FLAG, 8'h0);
      chk(q & 8'h02, 8'h00);
      trx_sleep <= 1'b0;
      repeat (20) @(posedge core_clk);
      rd(REG_CTRL0, 8'h00);
      bus(1'b1, REG_IRQ_FLAG, 8'h03);
      repeat (13000) @(posedge core_clk);
      bus(1'b0, REG_IRQ_FLAG, 8'h0);
      chk(q & 8'h02, 8'h02);
      $display("test sleep done");
      conclude();
   end
endmodule
